// file: rtl/host_buffer_access_ports.sv
// Buffer access ports of the host engine transfer memory, driven by 8-bit command codes
`timescale 1ns/1ns
module host_buffer_access_ports
  import buf_port_pkg::*;
#(
  parameter int ADDR_W   = 11,
  parameter int MS_TICKS = MS_CYCLES
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CMD_STROBE,
  input  wire logic [15:0] CMD_CODE,
  input  wire logic        WR_STROBE,
  input  wire logic [15:0] WR_DATA,
  input  wire logic        RD_STROBE,
  output logic      [15:0] RD_DATA,
  output logic             RD_VALID,
  input  wire logic [15:0] TRANSFER_COUNT,
  output logic             ALL_DONE,
  output logic      [1:0]  BUF_STATUS,
  output logic             ISO_B_SELECTED
);

  logic             rst_meta;
  logic             rst_n;
  port_sel_e        sel;
  logic             sel_write;
  logic             word_phase;
  logic [15:0]      iso_size;
  logic [15:0]      win_count;
  logic [14:0]      win_addr;
  logic [3:0]       swap_period;
  logic [15:0]      ptr;
  logic [15:0]      base;
  logic [15:0]      moved;
  logic [15:0]      limit;
  logic             mem_sel;
  logic             wr_access;
  logic             rd_access;
  logic             access;
  logic             mem_go;
  logic             last_word;
  logic [15:0]      byte_addr;
  logic [15:0]      reg_value;
  logic             rd_pend;
  logic             rd_from_mem;
  logic [15:0]      rd_hold;
  logic [31:0]      ms_count;
  logic [3:0]       ms_elapsed;
  logic             swap_now;
  logic             ms_tick;
  logic [1:0]       in_use;

  buf_mem_if #(.ADDR_W(ADDR_W), .DATA_W(16)) mem ();

  transfer_ram #(.ADDR_W(ADDR_W), .DATA_W(16)) u_ram (
    .clk (SYS_CLK),
    .mem (mem)
  );

  // Reset release through two flip-flops
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Data phase qualifiers
  assign mem_sel   = (sel == SEL_ISO_A) || (sel == SEL_ISO_B) || (sel == SEL_DIRECT);
  assign wr_access = WR_STROBE && sel_write && !CMD_STROBE;
  assign rd_access = RD_STROBE && !sel_write && !CMD_STROBE;
  assign access    = wr_access || rd_access;
  assign mem_go    = access && mem_sel && (moved < limit);
  assign last_word = (moved + BYTES_PER_WORD) >= limit;
  assign byte_addr = base + ptr;

  // Memory port: word address from the byte pointer
  assign mem.we    = mem_go && wr_access;
  assign mem.addr  = byte_addr[ADDR_W:1];
  assign mem.wdata = WR_DATA;

  // Command decode selects the port and its direction
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel       <= SEL_NONE;
      sel_write <= 1'b0;
    end
    else if (CMD_STROBE)
    begin
      sel_write <= CMD_CODE[CMD_WRITE_BIT];
      if ((CMD_CODE[7:0] == CMD_ISO_SIZE_RD) || (CMD_CODE[7:0] == CMD_ISO_SIZE_WR))
        sel <= SEL_SIZE;
      else if ((CMD_CODE[7:0] == CMD_WINDOW_RD) || (CMD_CODE[7:0] == CMD_WINDOW_WR))
        sel <= SEL_WINDOW;
      else if ((CMD_CODE[7:0] == CMD_ISO_A_RD) || (CMD_CODE[7:0] == CMD_ISO_A_WR))
        sel <= SEL_ISO_A;
      else if ((CMD_CODE[7:0] == CMD_ISO_B_RD) || (CMD_CODE[7:0] == CMD_ISO_B_WR))
        sel <= SEL_ISO_B;
      else if ((CMD_CODE[7:0] == CMD_DIRECT_RD) || (CMD_CODE[7:0] == CMD_DIRECT_WR))
        sel <= SEL_DIRECT;
      else if ((CMD_CODE[7:0] == CMD_SWAP_RD) || (CMD_CODE[7:0] == CMD_SWAP_WR))
        sel <= SEL_SWAP;
      else
        sel <= SEL_NONE;
    end
  end

  // Address word first, count word second for the window
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      word_phase <= 1'b0;
    else if (CMD_STROBE)
      word_phase <= 1'b0;
    else if (access && (sel == SEL_WINDOW))
      word_phase <= !word_phase;
  end

  // Configuration register writes
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iso_size    <= ISO_SIZE_RESET;
      win_count   <= WIN_COUNT_RESET;
      win_addr    <= WIN_ADDR_RESET;
      swap_period <= SWAP_RESET;
    end
    else if (wr_access)
    begin
      case (sel)
        SEL_SIZE:   iso_size <= WR_DATA;
        SEL_WINDOW:
        begin
          if (word_phase)
            win_count <= WR_DATA;
          else
            win_addr <= WR_DATA[WIN_ADDR_MSB:0];
        end
        SEL_SWAP:   swap_period <= WR_DATA[SWAP_FIELD_MSB:0];
        default:    swap_period <= swap_period;
      endcase
    end
  end

  // Readback value of the selected register, reserved bits read zero
  always_comb
  begin
    case (sel)
      SEL_SIZE:   reg_value = iso_size;
      SEL_WINDOW: reg_value = word_phase ? win_count : {1'b0, win_addr};
      SEL_SWAP:   reg_value = {12'h000, swap_period};
      default:    reg_value = 16'h0000;
    endcase
  end

  // Transfer pointer: start on command, advance per word
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ptr   <= STREAM_START;
      base  <= STREAM_START;
      moved <= 16'h0000;
      limit <= 16'h0000;
    end
    else if (CMD_STROBE)
    begin
      moved <= 16'h0000;
      if ((CMD_CODE[7:0] == CMD_ISO_A_RD) || (CMD_CODE[7:0] == CMD_ISO_A_WR))
      begin
        ptr   <= STREAM_START;
        base  <= STREAM_START;
        limit <= TRANSFER_COUNT;
      end
      else if ((CMD_CODE[7:0] == CMD_ISO_B_RD) || (CMD_CODE[7:0] == CMD_ISO_B_WR))
      begin
        ptr   <= STREAM_START;
        base  <= iso_size;
        limit <= TRANSFER_COUNT;
      end
      else
      begin
        ptr   <= {1'b0, win_addr};
        base  <= STREAM_START;
        limit <= win_count;
      end
    end
    else if (mem_go)
    begin
      ptr   <= ptr + BYTES_PER_WORD;
      moved <= moved + BYTES_PER_WORD;
    end
  end

  // Completion pulse when an isochronous transfer reaches the loaded count; none for the direct port
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ALL_DONE <= 1'b0;
    else
      ALL_DONE <= mem_go && last_word && (sel != SEL_DIRECT);
  end

  // Read pipeline: two cycles from strobe to data
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_pend     <= 1'b0;
      rd_from_mem <= 1'b0;
      rd_hold     <= 16'h0000;
      RD_DATA     <= 16'h0000;
      RD_VALID    <= 1'b0;
    end
    else
    begin
      rd_pend     <= rd_access;
      rd_from_mem <= rd_access && mem_go;
      rd_hold     <= reg_value;
      RD_VALID    <= rd_pend;
      if (rd_pend)
        RD_DATA <= rd_from_mem ? mem.rdata : rd_hold;
    end
  end

  // Swap falls on a millisecond tick once the period has run out; period zero never swaps
  assign ms_tick  = (ms_count == 32'(MS_TICKS - 1));
  assign swap_now = ms_tick && (swap_period != 4'h0) &&
                    (({1'b0, ms_elapsed} + 5'h01) >= {1'b0, swap_period});

  // Millisecond counter and whole milliseconds since the last swap, the latter held at zero while the swap period is zero
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ms_count   <= 32'h00000000;
      ms_elapsed <= 4'h0;
    end
    else
    begin
      ms_count <= ms_tick ? 32'h00000000 : ms_count + 32'h00000001;
      if (swap_now || (swap_period == 4'h0))
        ms_elapsed <= 4'h0;
      else if (ms_tick)
        ms_elapsed <= ms_elapsed + 4'h1;
    end
  end

  // Buffer alternation and in-use status; a fill wins over a release
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ISO_B_SELECTED <= 1'b0;
      in_use         <= 2'b00;
    end
    else
    begin
      if (swap_now)
      begin
        ISO_B_SELECTED <= !ISO_B_SELECTED;
        in_use[ISO_B_SELECTED] <= 1'b0;
      end
      if (mem_go && last_word && wr_access && (sel == SEL_ISO_A))
        in_use[0] <= 1'b1;
      if (mem_go && last_word && wr_access && (sel == SEL_ISO_B))
        in_use[1] <= 1'b1;
    end
  end

  // Status output straight from a flip-flop
  always_ff @(posedge SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      BUF_STATUS <= 2'b00;
    else
      BUF_STATUS <= in_use;
  end

endmodule

// file: rtl/buf_port_pkg.sv
// Command codes, field layout, reset values and timing of the buffer access ports
package buf_port_pkg;

  // Read and write command codes; bit 7 of a code marks a write
  localparam logic [7:0] CMD_ISO_SIZE_RD = 8'h30;
  localparam logic [7:0] CMD_ISO_SIZE_WR = 8'hb0;
  localparam logic [7:0] CMD_WINDOW_RD   = 8'h32;
  localparam logic [7:0] CMD_WINDOW_WR   = 8'hb2;
  localparam logic [7:0] CMD_ISO_A_RD    = 8'h40;
  localparam logic [7:0] CMD_ISO_A_WR    = 8'hc0;
  localparam logic [7:0] CMD_ISO_B_RD    = 8'h42;
  localparam logic [7:0] CMD_ISO_B_WR    = 8'hc2;
  localparam logic [7:0] CMD_DIRECT_RD   = 8'h45;
  localparam logic [7:0] CMD_DIRECT_WR   = 8'hc5;
  localparam logic [7:0] CMD_SWAP_RD     = 8'h47;
  localparam logic [7:0] CMD_SWAP_WR     = 8'hc7;
  localparam int         CMD_WRITE_BIT   = 7;

  // Field positions
  localparam int WIN_ADDR_MSB   = 14;
  localparam int SWAP_FIELD_MSB = 3;

  // Values after reset, and the pointer step per word
  localparam logic [15:0] ISO_SIZE_RESET   = 16'h0000;
  localparam logic [15:0] WIN_COUNT_RESET  = 16'h0000;
  localparam logic [14:0] WIN_ADDR_RESET   = 15'h0000;
  localparam logic [3:0]  SWAP_RESET       = 4'h0;
  localparam logic [15:0] STREAM_START     = 16'h0000;
  localparam logic [15:0] BYTES_PER_WORD   = 16'h0002;

  // One millisecond at the system clock rate
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;

  // Port selected by the last command, one-hot
  typedef enum logic [6:0] {
    SEL_NONE   = 7'b0000001,
    SEL_SIZE   = 7'b0000010,
    SEL_WINDOW = 7'b0000100,
    SEL_ISO_A  = 7'b0001000,
    SEL_ISO_B  = 7'b0010000,
    SEL_DIRECT = 7'b0100000,
    SEL_SWAP   = 7'b1000000
  } port_sel_e;

endpackage

// file: rtl/buf_mem_if.sv
// Word access path between the port logic and the transfer memory
`timescale 1ns/1ns
interface buf_mem_if #(parameter int ADDR_W = 11, parameter int DATA_W = 16);
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport master (output we, output addr, output wdata, input rdata);
  modport ram    (input we, input addr, input wdata, output rdata);
endinterface

// file: rtl/transfer_ram.sv
// Transfer memory shared by the two isochronous buffers and the direct port
`timescale 1ns/1ns
module transfer_ram #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 16
) (
  input  wire logic  clk,
  buf_mem_if.ram     mem
);

  logic [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

  // Synchronous write, registered read one cycle after the address
  always_ff @(posedge clk)
  begin
    if (mem.we)
    begin
      words[mem.addr] <= mem.wdata;
    end
    mem.rdata <= words[mem.addr];
  end

endmodule

// file: sim/host_cpu.sv
// Host processor model issuing command codes and data words
`timescale 1ns/1ns
module host_cpu (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output logic             cmd_stb,
  output logic      [15:0] cmd_code,
  output logic             wr_stb,
  output logic      [15:0] wr_data,
  output logic             rd_stb,
  output logic      [15:0] tcount
);
  // Idle strobes at time zero
  initial
  begin
    cmd_stb = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    cmd_code = 16'h0000;
    wr_data = 16'h0000;
    tcount = 16'h0000;
  end
  // One strobe cycle on the chosen lines; the lines used flip once released
  task automatic pulse(input logic c, input logic w, input logic r, input logic [15:0] v);
    @(posedge clk);
    cmd_stb <= c;
    wr_stb <= w;
    rd_stb <= r;
    if (c)
      cmd_code <= v;
    if (w)
      wr_data <= v;
    @(posedge clk);
    cmd_stb <= 1'b0;
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    if (c)
      cmd_code <= ~v;
    if (w)
      wr_data <= ~v;
  endtask
  // One command pulse
  task automatic cmd(input logic [7:0] c);
    pulse(1'b1, 1'b0, 1'b0, {8'h00, c});
  endtask
  // One write word
  task automatic wr(input logic [15:0] d);
    pulse(1'b0, 1'b1, 1'b0, d);
  endtask
  // One read word, answer awaited for a few edges
  task automatic rd(output logic [15:0] d);
    int i;
    pulse(1'b0, 1'b0, 1'b1, 16'h0000);
    d = 16'hxxxx;
    for (i = 0; i < 4; i++)
    begin
      @(posedge clk);
      if (rd_valid === 1'b1)
      begin
        d = rd_data;
        break;
      end
    end
  endtask
  // Window programmed before any direct port use
  task automatic window(input logic [15:0] a, input logic [15:0] n);
    cmd(8'hb2);
    wr(a);
    wr(n);
  endtask
  // Transfer counter loaded ahead of a stream
  task automatic set_count(input logic [15:0] n);
    @(posedge clk);
    tcount <= n;
  endtask
endmodule

// file: sim/buf_port_checker.sv
// Assertions on the buffer access port pins
`timescale 1ns/1ns
module buf_port_checker
  import buf_port_pkg::*;
#(
  parameter int MS_TICKS = MS_CYCLES
) (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        CMD_STROBE,
  input wire logic [15:0] CMD_CODE,
  input wire logic        WR_STROBE,
  input wire logic [15:0] WR_DATA,
  input wire logic        RD_STROBE,
  input wire logic        RD_VALID,
  input wire logic        ALL_DONE,
  input wire logic [1:0]  BUF_STATUS,
  input wire logic        ISO_B_SELECTED
);
  logic [7:0] last_cmd;
  logic [3:0] per;
  logic       armed;
  int         gap;
  wire        rd_ok = RD_STROBE && !CMD_STROBE && !last_cmd[7];
  wire        swap_wr = WR_STROBE && !CMD_STROBE && last_cmd == CMD_SWAP_WR;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  // Last command and programmed swap period
  always_ff @(posedge SYS_CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      last_cmd <= 8'hff;
      per <= 4'h0;
    end
    else
    begin
      if (CMD_STROBE)
        last_cmd <= CMD_CODE[7:0];
      if (swap_wr)
        per <= WR_DATA[3:0];
    end
  // Cycles since the last swap
  always_ff @(posedge SYS_CLK or negedge RESET_N)
    if (!RESET_N)
    begin
      gap <= 0;
      armed <= 1'b0;
    end
    else
    begin
      gap <= $changed(ISO_B_SELECTED) ? 0 : gap + 1;
      armed <= swap_wr ? 1'b0 : (armed || $changed(ISO_B_SELECTED));
    end
  sequence s_b_done; ALL_DONE && last_cmd == CMD_ISO_B_WR; endsequence
  sequence s_a_done; ALL_DONE && last_cmd == CMD_ISO_A_WR; endsequence
  property p_rd_lat; rd_ok |-> ##2 RD_VALID; endproperty
  property p_rd_cause; RD_VALID |-> $past(rd_ok, 2); endproperty
  property p_done_pulse; ALL_DONE |=> !ALL_DONE; endproperty
  property p_done_cause;
    ALL_DONE |-> $past(WR_STROBE) || $past(RD_STROBE) || $past(RD_STROBE, 2)
      || $past(RD_STROBE, 3);
  endproperty
  property p_stat_b; s_b_done |-> ##[1:2] BUF_STATUS[1]; endproperty
  property p_stat_a; s_a_done |-> ##[1:2] BUF_STATUS[0]; endproperty
  property p_swap_zero;
    per == 4'h0 && $past(per) == 4'h0 |-> $stable(ISO_B_SELECTED);
  endproperty
  property p_swap_gap;
    $changed(ISO_B_SELECTED) && armed |-> gap == int'(per) * MS_TICKS - 1;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not on time");
  a_rd_cause: assert property (p_rd_cause) else $error("read answer unasked");
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  a_done_cause: assert property (p_done_cause) else $error("done without word");
  a_stat_b: assert property (p_stat_b) else $error("iso B status not set");
  a_stat_a: assert property (p_stat_a) else $error("iso A status not set");
  a_swap_zero: assert property (p_swap_zero) else $error("swap with period 0");
  a_swap_gap: assert property (p_swap_gap) else $error("swap period wrong");
endmodule
bind host_buffer_access_ports buf_port_checker #(.MS_TICKS(MS_TICKS)) i_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE),
  .WR_STROBE(WR_STROBE), .WR_DATA(WR_DATA), .RD_STROBE(RD_STROBE), .RD_VALID(RD_VALID),
  .ALL_DONE(ALL_DONE), .BUF_STATUS(BUF_STATUS), .ISO_B_SELECTED(ISO_B_SELECTED));

// file: sim/test_host_buffer_access_ports.sv
// Self-checking bench for the buffer access ports
`timescale 1ns/1ns
module test_host_buffer_access_ports
  import buf_port_pkg::*;
;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
  localparam int MS = 10;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        cmd_stb, wr_stb, rd_stb, rd_valid, all_done, iso_b;
  logic [15:0] cmd_code, wr_data, rd_data, tcount, d;
  logic [1:0]  buf_status;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          dones = 0;
  host_cpu i_host (.clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb), .tcount(tcount));
  host_buffer_access_ports #(.MS_TICKS(MS)) i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .CMD_STROBE(cmd_stb), .CMD_CODE(cmd_code), .WR_STROBE(wr_stb), .WR_DATA(wr_data),
    .RD_STROBE(rd_stb), .RD_DATA(rd_data), .RD_VALID(rd_valid), .TRANSFER_COUNT(tcount),
    .ALL_DONE(all_done), .BUF_STATUS(buf_status), .ISO_B_SELECTED(iso_b));
  // Clock, done counter and hang limit
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (all_done === 1'b1)
      dones++;
    if (cycles == 20000)
    begin
      failures++;
      report_and_stop();
    end
  end
  task automatic set_reset(input logic v);
    @(posedge sys_clk);
    reset_n <= v;
  endtask
  task automatic rd_chk(input logic [15:0] e);
    i_host.rd(d);
    `CHK(d, e)
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_reset();
    `CHK(buf_status, 2'b00)
    i_host.cmd(CMD_ISO_SIZE_RD);
    rd_chk(16'h0000);
    i_host.cmd(CMD_WINDOW_RD);
    rd_chk(16'h0000);
    rd_chk(16'h0000);
    i_host.cmd(CMD_SWAP_RD);
    rd_chk(16'h0000);
    $display("t_reset ended");
  endtask
  task automatic t_regs();
    i_host.cmd(CMD_ISO_SIZE_WR);
    i_host.wr(16'h0010);
    i_host.cmd(CMD_ISO_SIZE_RD);
    rd_chk(16'h0010);
    i_host.pulse(1'b1, 1'b1, 1'b0, {8'h00, CMD_ISO_SIZE_WR});
    i_host.cmd(CMD_ISO_SIZE_RD);
    i_host.pulse(1'b0, 1'b1, 1'b0, 16'h1234);
    rd_chk(16'h0010);
    i_host.window(16'hffff, 16'h8006);
    i_host.cmd(CMD_WINDOW_RD);
    rd_chk(16'h7fff);
    rd_chk(16'h8006);
    i_host.cmd(CMD_SWAP_WR);
    i_host.wr(16'hfff5);
    i_host.cmd(CMD_SWAP_RD);
    rd_chk(16'h0005);
    i_host.cmd(CMD_SWAP_WR);
    i_host.wr(16'h0000);
    $display("t_regs ended");
  endtask
  task automatic t_direct();
    i_host.window(16'h0100, 16'h0003);
    i_host.cmd(CMD_DIRECT_WR);
    i_host.wr(16'ha1b2);
    i_host.wr(16'hc3d4);
    i_host.window(16'h0100, 16'h0004);
    i_host.cmd(CMD_DIRECT_RD);
    rd_chk(16'ha1b2);
    rd_chk(16'hc3d4);
    rd_chk(16'h0000);
    i_host.window(16'h0102, 16'h0002);
    i_host.cmd(CMD_DIRECT_RD);
    rd_chk(16'hc3d4);
    $display("t_direct ended");
  endtask
  task automatic t_stream();
    i_host.set_count(16'h0004);
    i_host.cmd(CMD_ISO_B_WR);
    i_host.wr(16'h1111);
    i_host.wr(16'h2222);
    repeat (3) @(posedge sys_clk);
    `CHK(dones, 1)
    `CHK(buf_status, 2'b10)
    i_host.cmd(CMD_ISO_B_RD);
    rd_chk(16'h1111);
    rd_chk(16'h2222);
    rd_chk(16'h0000);
    i_host.window(16'h0010, 16'h0002);
    i_host.cmd(CMD_DIRECT_RD);
    rd_chk(16'h1111);
    i_host.cmd(CMD_ISO_A_WR);
    i_host.wr(16'h3333);
    i_host.wr(16'h4444);
    i_host.cmd(CMD_ISO_A_RD);
    rd_chk(16'h3333);
    i_host.cmd(CMD_ISO_A_RD);
    rd_chk(16'h3333);
    rd_chk(16'h4444);
    `CHK(buf_status, 2'b11)
    $display("t_stream ended");
  endtask
  task automatic t_swap();
    int   n;
    logic last;
    i_host.cmd(CMD_SWAP_WR);
    i_host.wr(16'h0001);
    last = iso_b;
    for (n = 0; n < 40 && iso_b === last; n++)
      @(posedge sys_clk);
    last = iso_b;
    for (n = 0; n < 40 && iso_b === last; n++)
      @(posedge sys_clk);
    `CHK(n, MS)
    repeat (2 * MS) @(posedge sys_clk);
    `CHK(buf_status, 2'b00)
    i_host.cmd(CMD_SWAP_WR);
    i_host.wr(16'h0000);
    @(posedge sys_clk);
    last = iso_b;
    repeat (3 * MS) @(posedge sys_clk);
    `CHK(iso_b, last)
    $display("t_swap ended");
  endtask
  task automatic t_midreset();
    i_host.set_count(16'h0002);
    i_host.cmd(CMD_ISO_A_WR);
    i_host.wr(16'h5555);
    repeat (3) @(posedge sys_clk);
    `CHK(buf_status, 2'b01)
    i_host.cmd(8'h55);
    rd_chk(16'h0000);
    set_reset(1'b0);
    repeat (2) @(posedge sys_clk);
    `CHK(buf_status, 2'b00)
    `CHK(iso_b, 1'b0)
    set_reset(1'b1);
    repeat (3) @(posedge sys_clk);
    i_host.cmd(CMD_ISO_SIZE_RD);
    rd_chk(16'h0000);
    $display("t_midreset ended");
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (11) @(posedge sys_clk);
    set_reset(1'b1);
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_regs();
    t_direct();
    t_stream();
    t_swap();
    t_midreset();
    report_and_stop();
  end
endmodule
